// [logic/hsu_config.sv]
// top: configuration port pair, logical device select, mode registers and two channels
`default_nettype none
// Overview of operation
// [RQ1] writing 55h to index port 4Eh enters configuration mode
// [RQ2] in configuration mode, index 07h selects the logical device register
// [RQ3] data port 4Fh write under index 07h picks device 04h or 05h
// [RQ4] index F0h selects the mode register of the chosen device
// [RQ5] data port read returns the register selected by the index
// [RQ6] mode bit D1 enables high-speed divisor decoding for that channel
// [RQ7] host changes the high-speed bit by read-modify-write of the mode byte
// [RQ8] data port write replaces the selected register with the byte
// [RQ9] writing AAh to the index port leaves configuration mode
// [RQ10] line control write 80h sets divisor latch access; bases 3E8h and 2E8h
// [RQ11] with latch access set, offsets 0 and 1 hold divisor low and high
// [RQ12] high speed with divisor 8002h gives 230400 bits per second
// [RQ13] high speed with divisor 8001h gives 460800 bits per second
// [RQ14] host writes frame format to offset 3 with latch access cleared
// [RQ15] line control 03h means eight bits, no parity, one stop
// [RQ16] high rate needs both the mode bit and the special divisor
// [RQ17] outside configuration mode config ports change nothing
module hsu_config
  import hsu_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // host byte-wide i/o
  input wire hsu_io_s i_io,
  // read answer
  output logic [7:0] o_rdata,
  output logic o_rdata_valid,
  // configuration mode and channel state
  output logic o_cfg_mode,
  output hsu_chan_s o_chan_a,
  output hsu_chan_s o_chan_b,
  output logic [2:0] o_rate_a,
  output logic [2:0] o_rate_b
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic cfg_mode;
    logic [7:0] index;
    logic [7:0] dev_sel;
    logic [7:0] mode_a;
    logic [7:0] mode_b;
    logic [7:0] rdata;
    logic rvalid;
  } hsu_state_s;

  hsu_state_s st_q, st_d;
  logic idx_wr, dat_wr, dat_rd;
  logic sel_a, sel_b;
  logic [2:0] chan_ofs;
  logic [7:0] rd_a, rd_b;
  logic hit_a, hit_b;
  logic [7:0] lcr_a, lcr_b;
  logic [15:0] div_a, div_b;
  logic [7:0] cfg_rd;

  assign idx_wr = i_io.wr && i_io.addr == HSU_CFG_INDEX_PORT;
  assign dat_wr = i_io.wr && i_io.addr == HSU_CFG_DATA_PORT;
  assign dat_rd = i_io.rd && i_io.addr == HSU_CFG_DATA_PORT;
  assign chan_ofs = i_io.addr[2:0];
  // bases are 8-byte aligned, so the top 13 bits decode the channel
  assign sel_a = i_io.addr[15:3] == HSU_CHAN_A_BASE[15:3]; // [RQ10]
  assign sel_b = i_io.addr[15:3] == HSU_CHAN_B_BASE[15:3]; // [RQ10]

  // ------------------------------------------------------------
  // configuration read mux
  // ------------------------------------------------------------
  always_comb
  begin
    cfg_rd = HSU_RST_BYTE;
    if (st_q.index == HSU_IDX_DEV_SELECT)
      cfg_rd = st_q.dev_sel; // [RQ5]
    else if (st_q.index == HSU_IDX_MODE && st_q.dev_sel == HSU_DEV_CHAN_A)
      cfg_rd = st_q.mode_a; // [RQ5]
    else if (st_q.index == HSU_IDX_MODE && st_q.dev_sel == HSU_DEV_CHAN_B)
      cfg_rd = st_q.mode_b; // [RQ5]
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    st_d.rvalid = 1'b0;
    if (idx_wr)
    begin
      if (!st_q.cfg_mode)
      begin
        if (i_io.wdata == HSU_KEY_UNLOCK)
          st_d.cfg_mode = 1'b1; // [RQ1]
      end
      else if (i_io.wdata == HSU_KEY_LOCK)
        st_d.cfg_mode = 1'b0; // [RQ9]
      else
        st_d.index = i_io.wdata; // [RQ2] [RQ4]
    end
    // data port writes outside configuration mode are dropped
    if (dat_wr && st_q.cfg_mode) // [RQ17]
    begin
      if (st_q.index == HSU_IDX_DEV_SELECT)
        st_d.dev_sel = i_io.wdata; // [RQ3] [RQ8]
      else if (st_q.index == HSU_IDX_MODE && st_q.dev_sel == HSU_DEV_CHAN_A)
        st_d.mode_a = i_io.wdata; // [RQ8]
      else if (st_q.index == HSU_IDX_MODE && st_q.dev_sel == HSU_DEV_CHAN_B)
        st_d.mode_b = i_io.wdata; // [RQ8]
    end
    if (i_io.rd)
    begin
      st_d.rvalid = 1'b1;
      st_d.rdata = 8'hff;
      // config space floats high while locked, like an absent port
      if (dat_rd && st_q.cfg_mode)
        st_d.rdata = cfg_rd; // [RQ5]
      else if (sel_a && hit_a)
        st_d.rdata = rd_a;
      else if (sel_b && hit_b)
        st_d.rdata = rd_b;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      st_q.cfg_mode <= 1'b0;
      st_q.index <= HSU_RST_BYTE;
      st_q.dev_sel <= HSU_RST_BYTE;
      st_q.mode_a <= HSU_RST_BYTE;
      st_q.mode_b <= HSU_RST_BYTE;
      st_q.rdata <= HSU_RST_BYTE;
      st_q.rvalid <= 1'b0;
    end
    else
      st_q <= st_d;
  end

  // ------------------------------------------------------------
  // channels
  // ------------------------------------------------------------
  hsu_chan_regs u_chan_a (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_sel(sel_a),
    .i_wr(i_io.wr),
    .i_ofs(chan_ofs),
    .i_wdata(i_io.wdata),
    .i_high_speed(st_q.mode_a[HSU_MODE_HS_POS]), // [RQ6] [RQ16]
    .o_rdata(rd_a),
    .o_rdata_hit(hit_a),
    .o_line_ctrl(lcr_a),
    .o_divisor(div_a),
    .o_divisor_access_latch_bit(),
    .o_hs_rate(o_rate_a)
  );

  hsu_chan_regs u_chan_b (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_sel(sel_b),
    .i_wr(i_io.wr),
    .i_ofs(chan_ofs),
    .i_wdata(i_io.wdata),
    .i_high_speed(st_q.mode_b[HSU_MODE_HS_POS]), // [RQ6] [RQ16]
    .o_rdata(rd_b),
    .o_rdata_hit(hit_b),
    .o_line_ctrl(lcr_b),
    .o_divisor(div_b),
    .o_divisor_access_latch_bit(),
    .o_hs_rate(o_rate_b)
  );

  assign o_rdata = st_q.rdata;
  assign o_rdata_valid = st_q.rvalid;
  assign o_cfg_mode = st_q.cfg_mode;
  assign o_chan_a = '{mode: st_q.mode_a, line_ctrl: lcr_a, divisor: div_a};
  assign o_chan_b = '{mode: st_q.mode_b, line_ctrl: lcr_b, divisor: div_b};

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  chk_unlock_enter: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    idx_wr && i_io.wdata == 8'h55 |=> o_cfg_mode) // [RQ1]
    else $error("unlock did not enter configuration mode");
  chk_lock_exit: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_cfg_mode && idx_wr && i_io.wdata == 8'haa |=> !o_cfg_mode) // [RQ9]
    else $error("lock did not leave configuration mode");
  chk_dev_select: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_cfg_mode && st_q.index == 8'h07 && dat_wr |=> st_q.dev_sel == $past(i_io.wdata)) // [RQ3]
    else $error("logical device not selected");
  chk_index_load: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_cfg_mode && idx_wr && i_io.wdata == 8'hf0 |=> st_q.index == 8'hf0) // [RQ2]
    else $error("index not loaded");
  chk_locked_mode: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !o_cfg_mode && dat_wr |=> $stable(st_q.mode_a) && $stable(st_q.mode_b)) // [RQ17]
    else $error("mode register changed while locked");
  chk_mode_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_cfg_mode && dat_wr && st_q.index == 8'hf0 && st_q.dev_sel == 8'h04
    |=> o_chan_a.mode == $past(i_io.wdata)) // [RQ4]
    else $error("mode register not written");
  chk_read_back: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_cfg_mode && dat_rd && !dat_wr && !idx_wr |=> o_rdata_valid && o_rdata == $past(cfg_rd)) // [RQ5]
    else $error("configuration read returned wrong byte");
  chk_rate_230k: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_chan_b.mode[1] && o_chan_b.divisor == 16'h8002 |-> o_rate_b == 3'h2) // [RQ12]
    else $error("230400 rate not selected");
endmodule
`default_nettype wire

// [logic/hsu_pkg.sv]
// package: port addresses, register offsets, codes and reset values for the high speed uart config
`default_nettype none
package hsu_pkg;
  // ------------------------------------------------------------
  // host i/o port addresses
  // ------------------------------------------------------------
  localparam logic [15:0] HSU_CFG_INDEX_PORT = 16'h004e;
  localparam logic [15:0] HSU_CFG_DATA_PORT = 16'h004f;
  localparam logic [15:0] HSU_CHAN_A_BASE = 16'h03e8;
  localparam logic [15:0] HSU_CHAN_B_BASE = 16'h02e8;
  // ------------------------------------------------------------
  // configuration keys, index codes and logical device numbers
  // ------------------------------------------------------------
  localparam logic [7:0] HSU_KEY_UNLOCK = 8'h55;
  localparam logic [7:0] HSU_KEY_LOCK = 8'haa;
  localparam logic [7:0] HSU_IDX_DEV_SELECT = 8'h07;
  localparam logic [7:0] HSU_IDX_MODE = 8'hf0;
  localparam logic [7:0] HSU_DEV_CHAN_A = 8'h04;
  localparam logic [7:0] HSU_DEV_CHAN_B = 8'h05;
  // ------------------------------------------------------------
  // channel register offsets and fields
  // ------------------------------------------------------------
  localparam logic [2:0] HSU_OFS_DIV_LOW = 3'h0;
  localparam logic [2:0] HSU_OFS_DIV_HIGH = 3'h1;
  localparam logic [2:0] HSU_OFS_LINE_CTRL = 3'h3;
  localparam int HSU_LCR_DIVISOR_ACCESS_LATCH_BIT_POS = 7;
  localparam int HSU_MODE_HS_POS = 1;
  // ------------------------------------------------------------
  // reset values, high-speed divisor codes and effective-rate codes
  // ------------------------------------------------------------
  localparam logic [7:0] HSU_RST_BYTE = 8'h00;
  localparam logic [7:0] HSU_RST_LINE_CTRL = 8'h03;
  localparam logic [15:0] HSU_DIV_RST = 16'h000c;
  localparam logic [15:0] HSU_DIV_HS_230K = 16'h8002;
  localparam logic [15:0] HSU_DIV_HS_460K = 16'h8001;
  localparam logic [2:0] HSU_RATE_230K = 3'h2;
  localparam logic [2:0] HSU_RATE_460K = 3'h1;

  // host i/o access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } hsu_io_s;

  // per-channel programming state
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] line_ctrl;
    logic [15:0] divisor;
  } hsu_chan_s;
endpackage
`default_nettype wire

// [logic/hsu_chan_regs.sv]
// one serial channel: divisor latch, line control and the effective-rate decode
`default_nettype none
module hsu_chan_regs
  import hsu_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // host access, already decoded to this channel
  input wire logic i_sel,
  input wire logic i_wr,
  input wire logic [2:0] i_ofs,
  input wire logic [7:0] i_wdata,
  input wire logic i_high_speed,
  // state
  output logic [7:0] o_rdata,
  output logic o_rdata_hit,
  output logic [7:0] o_line_ctrl,
  output logic [15:0] o_divisor,
  output logic o_divisor_access_latch_bit,
  output logic [2:0] o_hs_rate
);
  typedef struct packed {
    logic [7:0] line_ctrl;
    logic [15:0] divisor;
  } hsu_cr_s;

  hsu_cr_s st_q, st_d;
  logic divisor_access_latch_bit;

  assign divisor_access_latch_bit = st_q.line_ctrl[HSU_LCR_DIVISOR_ACCESS_LATCH_BIT_POS];

  always_comb
  begin
    st_d = st_q;
    if (i_sel && i_wr)
    begin
      if (i_ofs == HSU_OFS_LINE_CTRL)
        st_d.line_ctrl = i_wdata; // [RQ10] [RQ15]
      else if (divisor_access_latch_bit && i_ofs == HSU_OFS_DIV_LOW)
        st_d.divisor[7:0] = i_wdata; // [RQ11]
      else if (divisor_access_latch_bit && i_ofs == HSU_OFS_DIV_HIGH)
        st_d.divisor[15:8] = i_wdata; // [RQ11]
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      st_q.line_ctrl <= HSU_RST_LINE_CTRL;
      st_q.divisor <= HSU_DIV_RST;
    end
    else
      st_q <= st_d;
  end

  always_comb
  begin
    o_rdata = HSU_RST_BYTE;
    o_rdata_hit = 1'b0;
    if (i_ofs == HSU_OFS_LINE_CTRL)
    begin
      o_rdata = st_q.line_ctrl;
      o_rdata_hit = 1'b1;
    end
    else if (divisor_access_latch_bit && i_ofs == HSU_OFS_DIV_LOW)
    begin
      o_rdata = st_q.divisor[7:0];
      o_rdata_hit = 1'b1;
    end
    else if (divisor_access_latch_bit && i_ofs == HSU_OFS_DIV_HIGH)
    begin
      o_rdata = st_q.divisor[15:8];
      o_rdata_hit = 1'b1;
    end
  end

  // high-rate code only when both the mode bit and the special divisor are present
  always_comb
  begin
    o_hs_rate = 3'h0;
    if (i_high_speed && st_q.divisor == HSU_DIV_HS_230K)
      o_hs_rate = HSU_RATE_230K; // [RQ12]
    else if (i_high_speed && st_q.divisor == HSU_DIV_HS_460K)
      o_hs_rate = HSU_RATE_460K; // [RQ13]
  end

  assign o_line_ctrl = st_q.line_ctrl;
  assign o_divisor = st_q.divisor;
  assign o_divisor_access_latch_bit = divisor_access_latch_bit;

  chk_div_low_load: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_sel && i_wr && divisor_access_latch_bit && i_ofs == HSU_OFS_DIV_LOW |=> o_divisor[7:0] == $past(i_wdata)) // [RQ11]
    else $error("divisor low byte not loaded");
  chk_lcr_no_div: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_sel && i_wr && !divisor_access_latch_bit && i_ofs == HSU_OFS_DIV_HIGH |=> $stable(o_divisor)) // [RQ11]
    else $error("divisor changed without latch access");
  chk_rate_460k: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_high_speed && o_divisor == 16'h8001 |-> o_hs_rate == 3'h1) // [RQ13]
    else $error("460800 rate not selected");
endmodule
`default_nettype wire

// [testbench/hsu_host_model.sv]
// host processor model: byte-wide i/o cycles and programming sequences
`default_nettype none
module hsu_host_model
  import hsu_pkg::*;
(
  // clock
  input wire logic i_sys_clk,
  // read answer
  input wire logic [7:0] i_rdata,
  // host i/o
  output hsu_io_s o_io
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rd_q;
  initial o_io = '0;
  // strobe stands one cycle; released lines show the inverse, never stale values
  task automatic cyc(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    o_io <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge i_sys_clk);
    o_io <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    #1;
    rd_q = i_rdata;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    cyc(1'b1, a, d);
  endtask
  task automatic rd(input logic [15:0] a);
    cyc(1'b0, a, 8'h00);
  endtask
  // read-modify-write keeps the other mode bits
  task automatic set_hs(input logic [7:0] dev, input logic on);
    wr(HSU_CFG_INDEX_PORT, HSU_KEY_UNLOCK);
    wr(HSU_CFG_INDEX_PORT, HSU_IDX_DEV_SELECT);
    wr(HSU_CFG_DATA_PORT, dev);
    wr(HSU_CFG_INDEX_PORT, HSU_IDX_MODE);
    rd(HSU_CFG_DATA_PORT);
    rd_q[HSU_MODE_HS_POS] = on;
    wr(HSU_CFG_DATA_PORT, rd_q);
    wr(HSU_CFG_INDEX_PORT, HSU_KEY_LOCK);
  endtask
  // leaves latch access set so the bytes can be read back
  task automatic load_div(input logic [15:0] base, input logic [15:0] div);
    wr(base + 16'h3, 8'h80);
    wr(base, div[7:0]);
    wr(base + 16'h1, div[15:8]);
  endtask
endmodule
`default_nettype wire

// [testbench/testbench.sv]
// self-checking bench for the high speed uart config block
`default_nettype none
module testbench
  import hsu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  hsu_io_s io;
  logic [7:0] rdata;
  logic rdata_valid;
  logic cfg_mode;
  hsu_chan_s chan_a;
  hsu_chan_s chan_b;
  logic [2:0] rate_a;
  logic [2:0] rate_b;
  int failures = 0;
  int checks_done = 0;
  logic [7:0] exp_q[$];
  logic [7:0] mode [2];
  logic [7:0] r;
  logic [15:0] base_t [3] = '{HSU_CHAN_A_BASE, HSU_CHAN_B_BASE, HSU_CHAN_A_BASE};
  logic [15:0] div_t [3] = '{HSU_DIV_HS_230K, HSU_DIV_HS_460K, HSU_DIV_RST};
  logic [2:0] rate_t [3] = '{HSU_RATE_230K, HSU_RATE_460K, 3'h0};
  always #4 i_sys_clk = ~i_sys_clk;
  // ------------------------------------------------------------
  // instances
  // ------------------------------------------------------------
  hsu_config DUT (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_io(io),
    .o_rdata(rdata), .o_rdata_valid(rdata_valid), .o_cfg_mode(cfg_mode),
    .o_chan_a(chan_a), .o_chan_b(chan_b), .o_rate_a(rate_a), .o_rate_b(rate_b)
  );
  hsu_host_model host (.i_sys_clk(i_sys_clk), .i_rdata(rdata), .o_io(io));
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  task automatic cmp_st(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
    cmp_st({8'h00, got}, {8'h00, exp});
  endtask
  task automatic expect_rd(input logic [15:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.rd(a);
  endtask
  task automatic settle;
    @(posedge i_sys_clk);
    #1;
  endtask
  task automatic results;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // valid stands one cycle, so the falling edge sees it exactly once
  always @(negedge i_sys_clk)
    if (rdata_valid === 1'b1)
      cmp_rd(rdata, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx);
  initial
  begin
    #20000;
    failures++;
    $display("unexpected at %0t: run hung", $time);
    results;
  end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial
  begin
    r = 8'($urandom(32'h88e86097));
    repeat (10) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    expect_rd(HSU_CFG_DATA_PORT, 8'hff);
    host.wr(HSU_CFG_INDEX_PORT, HSU_IDX_MODE);
    host.wr(HSU_CFG_DATA_PORT, 8'h5a);
    settle;
    cmp_st(16'(cfg_mode), 16'h0);
    cmp_st(16'(chan_a.mode), 16'h0);
    host.wr(HSU_CFG_INDEX_PORT, HSU_KEY_UNLOCK);
    settle;
    cmp_st(16'(cfg_mode), 16'h1);
    for (int i = 0; i < 2; i++)
    begin
      r = 8'($urandom()) & 8'hfd;
      host.wr(HSU_CFG_INDEX_PORT, HSU_IDX_DEV_SELECT);
      host.wr(HSU_CFG_DATA_PORT, i ? HSU_DEV_CHAN_B : HSU_DEV_CHAN_A);
      expect_rd(HSU_CFG_DATA_PORT, i ? HSU_DEV_CHAN_B : HSU_DEV_CHAN_A);
      host.wr(HSU_CFG_INDEX_PORT, HSU_IDX_MODE);
      expect_rd(HSU_CFG_DATA_PORT, 8'h00);
      host.wr(HSU_CFG_DATA_PORT, r);
      expect_rd(HSU_CFG_DATA_PORT, r);
      mode[i] = r;
    end
    host.wr(HSU_CFG_INDEX_PORT, HSU_KEY_LOCK);
    settle;
    cmp_st(16'(cfg_mode), 16'h0);
    host.wr(HSU_CFG_DATA_PORT, 8'h00);
    for (int i = 0; i < 2; i++)
    begin
      exp_q.push_back(mode[i]);
      host.set_hs(i ? HSU_DEV_CHAN_B : HSU_DEV_CHAN_A, 1'b1);
      mode[i] = mode[i] | 8'h02;
    end
    settle;
    cmp_st({chan_a.mode, chan_b.mode}, {mode[0], mode[1]});
    for (int i = 0; i < 3; i++)
    begin
      host.load_div(base_t[i], div_t[i]);
      expect_rd(base_t[i] + 16'h3, 8'h80);
      expect_rd(base_t[i], div_t[i][7:0]);
      expect_rd(base_t[i] + 16'h1, div_t[i][15:8]);
      cmp_st(16'(i == 1 ? rate_b : rate_a), 16'(rate_t[i]));
      host.wr(base_t[i] + 16'h3, HSU_RST_LINE_CTRL);
      expect_rd(base_t[i] + 16'h3, 8'h03);
      expect_rd(base_t[i], 8'hff);
      cmp_st(i == 1 ? chan_b.divisor : chan_a.divisor, div_t[i]);
    end
    exp_q.push_back(mode[1]);
    host.set_hs(HSU_DEV_CHAN_B, 1'b0);
    settle;
    cmp_st(16'(rate_b), 16'h0);
    cmp_st(chan_b.divisor, HSU_DIV_HS_460K);
    cmp_st(16'(exp_q.size()), 16'h0);
    results;
  end
endmodule
`default_nettype wire
